// ==== core/stp_top.sv ====
// Shared timer prescaler and clock select with AXI4-Lite registers
`timescale 1ns/100ps
`include "stp_cfg.svh"
module stp_top #(
  parameter int NUM_TIMERS = 2,
  parameter int PRESC_W    = `STP_PRESC_W,
  parameter int ADDR_W     = 4
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // External count pins and timer ticks
  input  wire logic [NUM_TIMERS-1:0] external_count_pin,
  output logic [NUM_TIMERS-1:0]      timer_tick
);

  if (NUM_TIMERS < 1 || NUM_TIMERS > 2) begin : g_chk_num
    $error("stp_top: NUM_TIMERS must be 1 or 2");
  end
  if (PRESC_W < `STP_TAP_DIV1024 || PRESC_W > 16) begin : g_chk_presc
    $error("stp_top: PRESC_W must be 10 to 16");
  end
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk_addr
    $error("stp_top: ADDR_W must be 4 to 32");
  end

  localparam int TW = `STP_TCNT_W;

  if (`STP_ST_TCNT_LSB + NUM_TIMERS * TW > 32) begin : g_chk_tcnt
    $error("stp_top: tick counters do not fit the status word");
  end
  if (`STP_ST_PCNT_LSB + PRESC_W > `STP_ST_TCNT_LSB) begin : g_chk_pcnt
    $error("stp_top: prescaler count overlaps the tick counters");
  end
  if (NUM_TIMERS * `STP_CS_STRIDE > 32) begin : g_chk_csel
    $error("stp_top: select fields do not fit the data word");
  end

  // Control register state
  logic                        sync_hold_mode_r;
  logic                        async_prescaler_reset_r;
  logic                        shared_prescaler_reset_r;
  stp_pkg::stp_cs_t            clock_select_field_r [NUM_TIMERS];

  // Prescaler and tap strobes
  logic [PRESC_W-1:0]          presc_r;
  logic [3:0]                  tap;

  // Tick generation
  logic [NUM_TIMERS-1:0]       tick_nxt;
  logic [NUM_TIMERS-1:0]       tick_r;
  logic [TW-1:0]               tick_cnt_r [NUM_TIMERS];

  // Bus slave state
  logic                        aw_held_r;
  logic                        w_held_r;
  logic [ADDR_W-1:0]           aw_addr_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;
  logic                        awready_r;
  logic                        wready_r;
  logic                        bvalid_r;
  logic [1:0]                  bresp_r;
  logic                        arready_r;
  logic                        rvalid_r;
  logic [31:0]                 rdata_r;
  logic [1:0]                  rresp_r;
  logic                        wr_fire;
  logic                        wr_gtc;
  logic                        wr_csel;
  logic                        wr_hit;
  logic [31:0]                 rd_val;
  logic                        rd_hit;

  // Edge strobes from the pin detectors
  stp_edge_if                  edge_bus [NUM_TIMERS] ();

  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_pin
    stp_pin_edge u_pin_edge (
      .clk    (clk),
      .resetn (resetn),
      .pin    (external_count_pin[t]),
      .edge_o (edge_bus[t])
    );
  end

  // Write address and data are captured in either order
  // A new write waits until the last response has been taken
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_gtc  = wr_fire && aw_addr_r[3:0] == `STP_OFS_GTC
                   && w_strb_r[0];
  assign wr_csel = wr_fire && aw_addr_r[3:0] == `STP_OFS_CLKSEL;
  assign wr_hit  = (aw_addr_r[3:0] == `STP_OFS_GTC)
                   || (aw_addr_r[3:0] == `STP_OFS_CLKSEL)
                   || (aw_addr_r[3:0] == `STP_OFS_STATUS);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      awready_r <= 1'b0;
    end else if (s_axi_awvalid && awready_r) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      awready_r <= 1'b0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else begin
      awready_r <= !aw_held_r && !bvalid_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      wready_r <= 1'b0;
    end else if (s_axi_wvalid && wready_r) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      wready_r <= 1'b0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else begin
      wready_r <= !w_held_r && !bvalid_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `STP_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Synchronisation mode bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_hold_mode_r <= 1'(`STP_GTC_RESET >> `STP_GTC_SYNC_BIT);
    end else if (wr_gtc) begin
      sync_hold_mode_r <= w_data_r[`STP_GTC_SYNC_BIT];
    end
  end

  // Prescaler reset bits: a write always wins over the hardware clear,
  // so a reset written without sync mode lasts exactly one cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      async_prescaler_reset_r  <= 1'(`STP_GTC_RESET >> `STP_GTC_APSR_BIT);
      shared_prescaler_reset_r <= 1'(`STP_GTC_RESET >> `STP_GTC_SPSR_BIT);
    end else if (wr_gtc) begin
      async_prescaler_reset_r  <= w_data_r[`STP_GTC_APSR_BIT];
      shared_prescaler_reset_r <= w_data_r[`STP_GTC_SPSR_BIT];
    end else if (!sync_hold_mode_r) begin
      async_prescaler_reset_r  <= 1'b0;
      shared_prescaler_reset_r <= 1'b0;
    end
  end

  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_csel
    always_ff @(posedge clk) begin
      if (!resetn) begin
        clock_select_field_r[t] <= stp_pkg::stp_cs_t'(`STP_CLKSEL_RESET);
      end else if (wr_csel && w_strb_r[t]) begin
        clock_select_field_r[t] <= stp_pkg::stp_cs_t'(
          w_data_r[t*`STP_CS_STRIDE +: `STP_CS_W]);
      end
    end
  end

  // Free-running shared prescaler, held at zero while reset is asserted
  always_ff @(posedge clk) begin
    if (!resetn) begin
      presc_r <= '0;
    end else if (shared_prescaler_reset_r) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + PRESC_W'(1);
    end
  end

  // A tap strobes when its low bits are all ones, i.e. about to wrap
  always_comb begin
    tap[0] = &presc_r[`STP_TAP_DIV8-1:0];
    tap[1] = &presc_r[`STP_TAP_DIV64-1:0];
    tap[2] = &presc_r[`STP_TAP_DIV256-1:0];
    tap[3] = &presc_r[`STP_TAP_DIV1024-1:0];
  end

  // Per-timer source select; ticks pause while the shared reset is held
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tick
    always_comb begin
      unique case (clock_select_field_r[t])
        stp_pkg::STP_CS_STOP:     tick_nxt[t] = 1'b0;
        stp_pkg::STP_CS_DIRECT:   tick_nxt[t] = 1'b1;
        stp_pkg::STP_CS_DIV8:     tick_nxt[t] = tap[0];
        stp_pkg::STP_CS_DIV64:    tick_nxt[t] = tap[1];
        stp_pkg::STP_CS_DIV256:   tick_nxt[t] = tap[2];
        stp_pkg::STP_CS_DIV1K:    tick_nxt[t] = tap[3];
        stp_pkg::STP_CS_EXT_FALL: tick_nxt[t] = edge_bus[t].fall;
        stp_pkg::STP_CS_EXT_RISE: tick_nxt[t] = edge_bus[t].rise;
      endcase
    end

    always_ff @(posedge clk) begin
      if (!resetn) begin
        tick_r[t]     <= 1'b0;
        tick_cnt_r[t] <= '0;
      end else begin
        tick_r[t] <= tick_nxt[t] && !shared_prescaler_reset_r;
        if (tick_r[t]) begin
          tick_cnt_r[t] <= tick_cnt_r[t] + TW'(1);
        end
      end
    end
  end

  assign timer_tick = tick_r;

  // Read decode
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[3:0])
      `STP_OFS_GTC: begin
        rd_val[`STP_GTC_SYNC_BIT] = sync_hold_mode_r;
        rd_val[`STP_GTC_APSR_BIT] = async_prescaler_reset_r;
        rd_val[`STP_GTC_SPSR_BIT] = shared_prescaler_reset_r;
      end
      `STP_OFS_CLKSEL: begin
        for (int t = 0; t < NUM_TIMERS; t++) begin
          rd_val[t*`STP_CS_STRIDE +: `STP_CS_W] = clock_select_field_r[t];
        end
      end
      `STP_OFS_STATUS: begin
        rd_val[`STP_ST_PCNT_LSB +: PRESC_W] = presc_r;
        for (int t = 0; t < NUM_TIMERS; t++) begin
          rd_val[`STP_ST_TCNT_LSB + t*TW +: TW] = tick_cnt_r[t];
        end
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data is taken from the decode at the address handshake
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= `STP_RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_val;
      rresp_r   <= rd_hit ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
    end else if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end else begin
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule : stp_top

// ==== core/stp_cfg.svh ====
// Register map, field positions, reset values and prescaler taps
// Contract
// - Select 1 ticks every I/O clock (code: no tick while the shared reset bit is set)
// - Taps divide by 8, 64, 256, 1024
// - One free-running prescaler shared by both timers
// - First prescaled tick within 1..N+1 cycles
// - Prescaler reset restarts period for both timers
// - Count pin synchronised, then edge detected
// - Input latch transparent while clock high
// - Select 7 rising, 6 falling, one tick each
// - Pin edge to tick 2.5..3.5 cycles
// - External ticks bypass the prescaler (code: still blocked while the shared reset bit is set)
// - Sync mode holds both prescaler reset bits
// - Clearing sync mode clears both reset bits
// - Shared reset bit self-clears unless sync mode
// - Select codes 0 stop through 7 rising
// - Pin edges count even when pin drives
`ifndef STP_CFG_SVH
`define STP_CFG_SVH

`define STP_OFS_GTC      4'h0
`define STP_OFS_CLKSEL   4'h4
`define STP_OFS_STATUS   4'h8

`define STP_GTC_SYNC_BIT   7
`define STP_GTC_APSR_BIT   1
`define STP_GTC_SPSR_BIT   0
`define STP_GTC_RESET      8'h00

`define STP_CS_W           3
`define STP_CS_STRIDE      8
`define STP_CLKSEL_RESET   3'h0

`define STP_ST_PCNT_LSB    0
`define STP_ST_TCNT_LSB    16
`define STP_TCNT_W         8

`define STP_PRESC_W        10
`define STP_TAP_DIV8       3
`define STP_TAP_DIV64      6
`define STP_TAP_DIV256     8
`define STP_TAP_DIV1024    10

`define STP_RESP_OKAY      2'h0
`define STP_RESP_SLVERR    2'h2

`endif

// ==== core/stp_pkg.sv ====
// Types shared by the timer prescaler block
package stp_pkg;

  typedef enum logic [2:0] {
    STP_CS_STOP   = 3'h0,
    STP_CS_DIRECT = 3'h1,
    STP_CS_DIV8   = 3'h2,
    STP_CS_DIV64  = 3'h3,
    STP_CS_DIV256 = 3'h4,
    STP_CS_DIV1K  = 3'h5,
    STP_CS_EXT_FALL = 3'h6,
    STP_CS_EXT_RISE = 3'h7
  } stp_cs_t;

endpackage : stp_pkg

// ==== core/stp_edge_if.sv ====
// Edge strobes from one count pin detector to the tick logic
`timescale 1ns/100ps
interface stp_edge_if;
  logic rise;
  logic fall;
  modport det (output rise, output fall);
  modport use_side (input rise, input fall);
endinterface : stp_edge_if

// ==== core/stp_pin_edge.sv ====
// Count pin synchroniser and edge detector for one timer
`timescale 1ns/100ps
module stp_pin_edge (
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    resetn,
  // Raw count pin, read whatever its port direction
  input  wire logic    pin,
  // Edge strobes
  stp_edge_if.det      edge_o
);

  logic lat;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // Open while the clock is high, so the flops see the level held low phase
  always_latch begin
    if (clk) begin
      lat <= pin;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= lat;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign edge_o.rise = sync2_r & ~prev_r;
  assign edge_o.fall = ~sync2_r & prev_r;

endmodule : stp_pin_edge

// ==== verification/stp_pin_model.sv ====
// Count pin source standing in for the two external timer clocks
`timescale 1ns/100ps
module stp_pin_model (
  // Clock
  input  wire logic       clk,
  // Count pins
  output logic      [1:0] pin
);
  initial pin = 2'b00;

  // Half period of h cycles, h of 2 or more keeps below clk/2.5
  task automatic burst(input int n, input int h, input int o);
    repeat (2 * n) begin
      repeat (h) @(posedge clk);
      #(o) pin = ~pin;
    end
    repeat (5) @(posedge clk); // Pins steady before select changes
  endtask : burst
endmodule : stp_pin_model

// ==== verification/stp_top_asserts.sv ====
// Checker on the bus and tick ports of the prescaler top
`timescale 1ns/100ps
`include "stp_cfg.svh"
module stp_top_asserts #(
  parameter int NUM_TIMERS = 2,
  parameter int ADDR_W     = 4
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // Write side
  input wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  // Read side
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  // Ticks
  input wire logic [NUM_TIMERS-1:0] timer_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Shadow of timer0 select, taken from the bus writes
  logic [2:0] sel0_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel0_r <= 3'h0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_wready && s_axi_wstrb[0] &&
                 s_axi_awaddr[3:0] == `STP_OFS_CLKSEL) begin
      sel0_r <= s_axi_wdata[2:0];
    end
  end

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read data missing");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  a_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_unmapped_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == `STP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ready_release: assert property ($rose(resetn) |->
    !s_axi_awready ##1 s_axi_awready)
    else $error("ready timing after reset wrong");
  a_stop_quiet: assert property (
    sel0_r == 3'h0 && $past(sel0_r, 3) == 3'h0 |-> !timer_tick[0])
    else $error("tick while stopped");
  a_div8_gap: assert property (
    sel0_r == 3'h2 && $past(sel0_r, 3) == 3'h2 && timer_tick[0] |=>
    !timer_tick[0] [*7])
    else $error("divide by eight spacing wrong");

  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp[1]);
  c_both_tick: cover property (&timer_tick);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : stp_top_asserts

// ==== verification/stp_top_test.sv ====
// Self-checking bench for the shared timer prescaler
`timescale 1ns/100ps
module stp_top_test;
  localparam logic [31:0] M  = 32'hffffffff;
  localparam logic [1:0]  OK = 2'h0;
  localparam logic [1:0]  ER = 2'h2;
  logic          clk = 1'b0, resetn = 1'b0, ext_on = 1'b0;
  logic [3:0]    s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic          s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic          s_axi_rready = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic          s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp, external_count_pin, timer_tick;
  int            error_cnt = 0, compares = 0, cyc = 0, d0, d1, n;
  int            dv[4] = '{8, 64, 256, 1024};
  realtime       t_rise = 0, t_fall = 0;
  logic [1:0]    bq[$];
  logic [65:0]   rq[$];
  logic [65:0]   re;

  stp_top dut (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .external_count_pin, .timer_tick
  );
  stp_pin_model u_pin (.clk, .pin(external_count_pin));

  always #25 clk = ~clk;

  task automatic stop_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_win(input realtime dt);
    compares++;
    if (dt < 125.0 || dt > 175.0) begin
      error_cnt++;
      $display("Error at %0t: pin to tick %0t ns", $time, dt);
    end
  endtask : chk_win

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    bq.push_back(e);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    // Ready follows the response a cycle late, so the response must stand
    while (1'b1) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready) break;
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] r);
    rq.push_back({r, m, e & m});
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready  <= 1'b0;
  endtask : rd

  task automatic wt(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (timer_tick[0] !== 1'b1);
  endtask : wt

  always @(posedge clk) begin
    if (resetn && s_axi_bvalid && s_axi_bready) begin
      chk(s_axi_bresp, bq.pop_front());
    end
    if (resetn && s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      chk(s_axi_rdata & re[63:32], re[31:0]);
      chk(s_axi_rresp, re[65:64]);
    end
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      stop_test();
    end
  end

  always @(posedge external_count_pin[0]) t_rise = $realtime;
  always @(negedge external_count_pin[1]) t_fall = $realtime;
  always @(posedge timer_tick[0]) if (ext_on) chk_win($realtime - t_rise);
  always @(posedge timer_tick[1]) if (ext_on) chk_win($realtime - t_fall);

  initial begin
    void'($urandom(20615));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(4'h0, 32'h0, M, OK);
    rd(4'h4, 32'h0, M, OK);
    rd(4'hc, 32'h0, M, ER);
    wr(4'hc, 32'h0, ER);
    wr(4'h0, 32'h83, OK);
    wr(4'h4, 32'h0101, OK);
    rd(4'h0, 32'h83, M, OK);
    rd(4'h8, 32'h0, M, OK);
    wr(4'h0, 32'h0, OK);
    repeat (3) @(posedge clk);
    repeat (8) @(posedge clk) chk(timer_tick, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, 32'h0200 | 32'(i + 2), OK);
      wt(d0);
      chk(32'(d0 <= dv[i] + 1), 32'h1);
      wt(d0);
      chk(d0, dv[i]);
      chk(timer_tick[1], 32'h1);
    end
    wr(4'h0, 32'h1, OK);
    rd(4'h0, 32'h0, M, OK);
    wr(4'h4, 32'h0302, OK);
    wr(4'h0, 32'h81, OK);
    wr(4'h0, 32'h0, OK);
    d0 = 0;
    d1 = 0;
    for (int k = 1; d1 == 0; k++) begin
      @(posedge clk);
      if (timer_tick[0] === 1'b1 && d0 == 0) d0 = k;
      if (timer_tick[1] === 1'b1) d1 = k;
    end
    chk(d1 - d0, 32'd56);
    rd(4'h0, 32'h0, M, OK);
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    n = $urandom_range(8, 3);
    wr(4'h4, 32'h0607, OK);
    ext_on = 1'b1;
    u_pin.burst(n, $urandom_range(4, 2), $urandom_range(49, 1));
    ext_on = 1'b0;
    wr(4'h4, 32'h0, OK);
    rd(4'h8, (n << 24) | (n << 16), 32'hffff0000, OK);
    stop_test();
  end
endmodule : stp_top_test

bind stp_top stp_top_asserts #(.NUM_TIMERS(NUM_TIMERS), .ADDR_W(ADDR_W))
  u_chk (
  .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_tick
);
